// file: bench/drc_ctrl_test.sv
/*
 drc_ctrl_test: self-checking bench for drc_ctrl driven by a bus master model.
 assumes the refresh period is shortened to P so that several refreshes fit.
*/
`timescale 1ns/1ps
module drc_ctrl_test;
	localparam int P = 64;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic [1:0] size = 2'h0;
	logic [drc_pkg::ADDR_W-1:0] addr = '0;
	logic [7:0] hold = 8'h0;
	drc_pkg::drc_pin_t pin;
	logic busy;
	logic timed_out;
	logic row_strobe_lower_n;
	logic row_strobe_upper_n;
	logic [3:0] col_strobe_n;
	logic width_ack_hi_n;
	logic width_ack_lo_n;
	logic [9:0] dram_mux_addr;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_ref = 0;
	int ref_start = 0;
	int ref_len = 0;
	logic [9:0] ref_row = 10'h0;
	logic ref_prev = 1'b0;
	logic ref_now = 1'b0;
	logic mon_on = 1'b0;
	logic [17:0] outs;

	assign outs = {row_strobe_lower_n, row_strobe_upper_n, col_strobe_n, width_ack_hi_n,
		width_ack_lo_n, dram_mux_addr};

	always #20 ref_clk = ~ref_clk;

	drc_master_model i_drc_master_model (
		.ref_clk(ref_clk),
		.start(start),
		.size(size),
		.addr(addr),
		.hold(hold),
		.ack_hi_n(width_ack_hi_n),
		.ack_lo_n(width_ack_lo_n),
		.pin(pin),
		.busy(busy),
		.timed_out(timed_out)
	);

	drc_ctrl #(.REFRESH_PERIOD(P)) i_drc_ctrl (
		.ref_clk(ref_clk),
		.reset(reset),
		.master_addr_strobe_n(pin.strobe_n),
		.xfer_size_hi(pin.size[1]),
		.xfer_size_lo(pin.size[0]),
		.master_addr(pin.addr),
		.row_strobe_lower_n(row_strobe_lower_n),
		.row_strobe_upper_n(row_strobe_upper_n),
		.col_strobe_n(col_strobe_n),
		.width_ack_hi_n(width_ack_hi_n),
		.width_ack_lo_n(width_ack_lo_n),
		.dram_mux_addr(dram_mux_addr)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	always @(posedge ref_clk) cyc <= cyc + 1;

	// refresh watcher: both rows low outside reset marks a refresh cycle
	always @(posedge ref_clk) begin
		#1;
		ref_now = mon_on && row_strobe_lower_n === 1'b0 && row_strobe_upper_n === 1'b0;
		if (ref_now) begin
			check(32'(col_strobe_n), 32'hf);
		end
		if (ref_now && !ref_prev) begin
			n_ref++;
			ref_start = cyc;
			ref_row = dram_mux_addr;
		end
		if (!ref_now && ref_prev) begin
			ref_len = cyc - ref_start;
		end
		ref_prev = ref_now;
	end

	task automatic wait_ref();
		int n0;
		int k;
		n0 = n_ref;
		for (k = 0; k < 2 * P + 8 && n_ref == n0; k++) tick();
		check(32'(n_ref - n0), 32'h1);
	endtask

	task automatic t_reset();
		mon_on = 1'b0;
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (16) tick();
		check(32'(outs), 32'h0);
		@(posedge ref_clk);
		reset <= 1'b0;
		tick();
		check(32'(outs[17:10]), 32'hff);
		mon_on = 1'b1;
		// row count restarts, so the first refresh uses the first increment
		wait_ref();
		check(32'(ref_row), 32'h1);
	endtask

	task automatic t_refresh();
		int c0;
		logic [9:0] r0;
		wait_ref();
		c0 = ref_start;
		r0 = ref_row;
		check(32'(r0[9]), 32'h0);
		repeat (drc_pkg::REF_RAS_MIN_CYCLES + 1) tick();
		check(32'(ref_len), 32'(drc_pkg::REF_RAS_MIN_CYCLES));
		wait_ref();
		check(32'(ref_start - c0), 32'(P));
		check(32'(ref_row), 32'(r0 + 10'h1));
	endtask

	task automatic t_access(input logic r, input logic [1:0] c, input logic [1:0] s,
		input logic [7:0] h);
		logic [9:0] rf;
		logic [9:0] cf;
		logic [3:0] ec;
		int k;
		rf = 10'h3c5 ^ {c, s, 6'h0};
		cf = 10'h1a3 ^ {6'h0, s, c};
		ec = 4'hf;
		for (k = 0; k < 4; k++) begin
			if (k >= int'(c) && k < int'(c) + ((s == 2'h0) ? 4 : int'(s))) begin
				ec[k] = 1'b0;
			end
		end
		@(posedge ref_clk);
		start <= 1'b1;
		size <= s;
		addr <= {r, rf, cf, c};
		hold <= h;
		@(posedge ref_clk);
		start <= 1'b0;
		for (k = 0; k < 40 && (row_strobe_lower_n ^ row_strobe_upper_n) !== 1'b1; k++) tick();
		check(32'({row_strobe_upper_n, row_strobe_lower_n}), r ? 32'h1 : 32'h2);
		check(32'({col_strobe_n, width_ack_hi_n, width_ack_lo_n}), 32'h3f);
		check(32'(dram_mux_addr), 32'(rf));
		tick();
		check(32'(col_strobe_n), 32'(ec));
		check(32'({width_ack_hi_n, width_ack_lo_n}), 32'h0);
		check(32'({row_strobe_upper_n, row_strobe_lower_n}), r ? 32'h1 : 32'h2);
		check(32'(dram_mux_addr), 32'(cf));
		repeat (h) begin
			tick();
			check(32'(col_strobe_n), 32'(ec));
		end
		for (k = 0; k < 40 && col_strobe_n !== 4'hf; k++) tick();
		check(32'(outs[17:10]), 32'hff);
		check(32'(busy), 32'h0);
		check(32'(timed_out), 32'h0);
	endtask

	// a transfer held past two due pulses leaves a refresh pending
	task automatic t_long();
		t_access(1'b1, 2'h1, 2'h2, 8'd150);
		tick();
		check(32'({row_strobe_upper_n, row_strobe_lower_n}), 32'h0);
	endtask

	initial begin
		t_reset();
		t_refresh();
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 4; c++) begin
				for (int s = 0; s < 4; s++) begin
					t_access(1'(r), 2'(c), 2'(s), 8'(2 + c));
				end
			end
		end
		t_long();
		t_reset();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		stop_test();
	end
endmodule

// file: bench/drc_master_model.sv
/*
 drc_master_model: behavioural bus master that opens one transfer per start
 request, holds it until the width acknowledge arrives or 64 clocks pass, then for hold more clocks, then ends it.
 assumes start, size, addr and hold are driven at rising edges of ref_clk.
*/
`timescale 1ns/1ps
module drc_master_model (
	input wire logic ref_clk,
	input wire logic start,
	input wire logic [1:0] size,
	input wire logic [drc_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] hold,
	input wire logic ack_hi_n,
	input wire logic ack_lo_n,
	output drc_pkg::drc_pin_t pin,
	output logic busy,
	output logic timed_out
);
	int n;

	initial begin
		pin = drc_pkg::PIN_RESET;
		busy = 1'b0;
		timed_out = 1'b0;
	end

	always begin
		@(posedge ref_clk);
		if (start && !busy) begin
			busy <= 1'b1;
			pin <= '{strobe_n: 1'b0, size: size, addr: addr};
			n = 0;
			// both acks high means wait states, so the cycle stays open
			do begin
				@(posedge ref_clk);
				n++;
			end while ((ack_hi_n | ack_lo_n) !== 1'b0 && n < 64);
			if (n >= 64) begin
				timed_out <= 1'b1;
			end
			repeat (hold) @(posedge ref_clk);
			pin.strobe_n <= 1'b1;
			@(posedge ref_clk);
			// released lines float: show the inverse, never a stale value
			pin.addr <= ~pin.addr;
			pin.size <= ~pin.size;
			busy <= 1'b0;
		end
	end
endmodule

// file: verilog/drc_ctrl.sv
/*
 drc_ctrl: top of the dram refresh controller. row/column strobe state
 machine, address multiplexer and refresh service for a two-row, four-column
 byte-wide dram behind a 32-bit bus master.
 assumes master pins are asynchronous to ref_clk and that address and size
 are stable while the master strobe is low.
*/
`timescale 1ns/1ps
module drc_ctrl #(
	parameter int REFRESH_PERIOD = drc_pkg::REFRESH_PERIOD,
	parameter int ROW_W = drc_pkg::ROW_CNT_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic master_addr_strobe_n,
	input wire logic xfer_size_hi,
	input wire logic xfer_size_lo,
	input wire logic [drc_pkg::ADDR_W-1:0] master_addr,
	output logic row_strobe_lower_n,
	output logic row_strobe_upper_n,
	output logic [drc_pkg::COLS-1:0] col_strobe_n,
	output logic width_ack_hi_n,
	output logic width_ack_lo_n,
	output logic [drc_pkg::MUX_ADDR_W-1:0] dram_mux_addr
);
	if (ROW_W >= drc_pkg::MUX_ADDR_W) begin : g_bad
		$error("drc_ctrl: refresh row does not fit the multiplexed address");
	end

	function automatic drc_pkg::drc_state_bits_t encode(drc_pkg::drc_state_t s);
		drc_pkg::drc_state_bits_t b;
		b = drc_pkg::BITS_RESET;
		unique case (s)
			drc_pkg::ST_BEGIN: b = 9'h000;
			drc_pkg::ST_IDLE: b = {4'hf, 1'b1, 1'b1, 1'b1, 2'h3};
			drc_pkg::ST_ROW0: b = {4'hf, 1'b0, 1'b1, 1'b1, 2'h0};
			drc_pkg::ST_ROW1: b = {4'hf, 1'b0, 1'b1, 1'b1, 2'h1};
			drc_pkg::ST_ROW2: b = {4'hf, 1'b0, 1'b1, 1'b1, 2'h2};
			drc_pkg::ST_ROW3: b = {4'hf, 1'b0, 1'b1, 1'b1, 2'h3};
			drc_pkg::ST_C0X1: b = {4'he, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C0X2: b = {4'hc, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C0X3: b = {4'h8, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C0X4: b = {4'h0, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C1X1: b = {4'hd, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C1X2: b = {4'h9, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C1X3: b = {4'h1, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C2X1: b = {4'hb, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C2X2: b = {4'h3, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_C3X1: b = {4'h7, 1'b0, 1'b0, 1'b1, 2'h3};
			drc_pkg::ST_REFRESH_FIRST: b = {4'hf, 1'b0, 1'b1, 1'b0, 2'h3};
			drc_pkg::ST_REFRESH_SECOND: b = {4'hf, 1'b0, 1'b1, 1'b0, 2'h2};
			default: b = drc_pkg::BITS_RESET;
		endcase
		return b;
	endfunction

	function automatic logic is_column(drc_pkg::drc_state_t s);
		return s inside {drc_pkg::ST_C0X1, drc_pkg::ST_C0X2, drc_pkg::ST_C0X3,
			drc_pkg::ST_C0X4, drc_pkg::ST_C1X1, drc_pkg::ST_C1X2, drc_pkg::ST_C1X3,
			drc_pkg::ST_C2X1, drc_pkg::ST_C2X2, drc_pkg::ST_C3X1};
	endfunction

	function automatic logic is_refresh(drc_pkg::drc_state_t s);
		return s inside {drc_pkg::ST_REFRESH_FIRST, drc_pkg::ST_REFRESH_SECOND};
	endfunction

	// pin synchroniser: s1 feeds only s2; a bit changes once s2 and s3 agree
	drc_pkg::drc_pin_t pin_in;
	drc_pkg::drc_pin_t pin_s1_q;
	drc_pkg::drc_pin_t pin_s2_q;
	drc_pkg::drc_pin_t pin_s3_q;
	drc_pkg::drc_pin_t pin_q;
	logic [$bits(drc_pkg::drc_pin_t)-1:0] pin_agree;

	assign pin_in = '{strobe_n: master_addr_strobe_n,
		size: {xfer_size_hi, xfer_size_lo},
		addr: master_addr};
	assign pin_agree = ~(pin_s2_q ^ pin_s3_q);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_s1_q <= drc_pkg::PIN_RESET;
			pin_s2_q <= drc_pkg::PIN_RESET;
			pin_s3_q <= drc_pkg::PIN_RESET;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_q <= drc_pkg::PIN_RESET;
		end else begin
			pin_q <= (pin_s2_q & pin_agree) | (pin_q & ~pin_agree);
		end
	end

	// refresh timer, request latch and row counter
	logic refresh_request;
	logic refresh_ack;
	logic [ROW_W-1:0] refresh_row;

	drc_refresh_timer #(
		.PERIOD(REFRESH_PERIOD),
		.ROW_W(ROW_W)
	) i_drc_refresh_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.refresh_ack(refresh_ack),
		.due_pulse(),
		.refresh_request(refresh_request),
		.refresh_row(refresh_row)
	);

	// state machine
	drc_pkg::drc_state_t state_q;
	drc_pkg::drc_state_t state_d;
	drc_pkg::drc_state_bits_t state_bits_q;
	drc_pkg::drc_state_bits_t bits_d;
	logic [drc_pkg::HOLD_W-1:0] ref_hold_q;
	logic ref_hold_done;

	localparam logic [drc_pkg::HOLD_W-1:0] HOLD_LAST =
		drc_pkg::HOLD_W'(drc_pkg::REFRESH_SECOND_CYCLES - 1);

	assign ref_hold_done = (ref_hold_q == HOLD_LAST);
	assign refresh_ack = ~state_bits_q.refresh_n;
	assign bits_d = encode(state_d);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			drc_pkg::ST_BEGIN: begin
				state_d = drc_pkg::ST_IDLE;
			end
			drc_pkg::ST_IDLE: begin
				if (refresh_request) begin
					state_d = drc_pkg::ST_REFRESH_FIRST;
				end else if (!pin_q.strobe_n) begin
					unique case (pin_q.addr[1:0])
						2'h0: state_d = drc_pkg::ST_ROW0;
						2'h1: state_d = drc_pkg::ST_ROW1;
						2'h2: state_d = drc_pkg::ST_ROW2;
						2'h3: state_d = drc_pkg::ST_ROW3;
					endcase
				end
			end
			drc_pkg::ST_ROW0: begin
				unique case (pin_q.size)
					drc_pkg::SIZE_8: state_d = drc_pkg::ST_C0X1;
					drc_pkg::SIZE_16: state_d = drc_pkg::ST_C0X2;
					drc_pkg::SIZE_24: state_d = drc_pkg::ST_C0X3;
					drc_pkg::SIZE_32: state_d = drc_pkg::ST_C0X4;
				endcase
			end
			// larger sizes are clipped at the last column
			drc_pkg::ST_ROW1: begin
				if (pin_q.size == drc_pkg::SIZE_8) begin
					state_d = drc_pkg::ST_C1X1;
				end else if (pin_q.size == drc_pkg::SIZE_16) begin
					state_d = drc_pkg::ST_C1X2;
				end else begin
					state_d = drc_pkg::ST_C1X3;
				end
			end
			drc_pkg::ST_ROW2: begin
				if (pin_q.size == drc_pkg::SIZE_8) begin
					state_d = drc_pkg::ST_C2X1;
				end else begin
					state_d = drc_pkg::ST_C2X2;
				end
			end
			drc_pkg::ST_ROW3: begin
				state_d = drc_pkg::ST_C3X1;
			end
			drc_pkg::ST_C0X1, drc_pkg::ST_C0X2, drc_pkg::ST_C0X3, drc_pkg::ST_C0X4,
			drc_pkg::ST_C1X1, drc_pkg::ST_C1X2, drc_pkg::ST_C1X3,
			drc_pkg::ST_C2X1, drc_pkg::ST_C2X2, drc_pkg::ST_C3X1: begin
				if (pin_q.strobe_n) begin
					state_d = drc_pkg::ST_IDLE;
				end
			end
			drc_pkg::ST_REFRESH_FIRST: begin
				state_d = drc_pkg::ST_REFRESH_SECOND;
			end
			drc_pkg::ST_REFRESH_SECOND: begin
				if (ref_hold_done) begin
					state_d = drc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = drc_pkg::ST_BEGIN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= drc_pkg::ST_BEGIN;
			state_bits_q <= drc_pkg::BITS_RESET;
		end else begin
			state_q <= state_d;
			state_bits_q <= bits_d;
		end
	end

	// stretches refresh state two so the row strobe meets its minimum low time
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_hold_q <= '0;
		end else if (state_q == drc_pkg::ST_REFRESH_SECOND && !ref_hold_done) begin
			ref_hold_q <= ref_hold_q + 1'b1;
		end else begin
			ref_hold_q <= '0;
		end
	end

	// outputs: rows, acks and mux each their own flop, column strobes straight from the state bits, all in step
	logic row_lower_q;
	logic row_upper_q;
	logic ack_hi_q;
	logic ack_lo_q;
	logic [drc_pkg::MUX_ADDR_W-1:0] mux_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			row_lower_q <= 1'b0;
			row_upper_q <= 1'b0;
		end else begin
			row_lower_q <= ~((~bits_d.row_n & ~pin_q.addr[drc_pkg::ROW_SEL_BIT])
				| ~bits_d.refresh_n);
			row_upper_q <= ~((~bits_d.row_n & pin_q.addr[drc_pkg::ROW_SEL_BIT])
				| ~bits_d.refresh_n);
		end
	end

	// one common acknowledge feeds both width lines: the port is 32 bits
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ack_hi_q <= 1'b0;
			ack_lo_q <= 1'b0;
		end else begin
			ack_hi_q <= bits_d.ack_n;
			ack_lo_q <= bits_d.ack_n;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mux_q <= '0;
		end else if (is_refresh(state_d)) begin
			mux_q <= {{(drc_pkg::MUX_ADDR_W - ROW_W){1'b0}}, refresh_row};
		end else if (is_column(state_d)) begin
			mux_q <= pin_q.addr[drc_pkg::COL_ADDR_LSB +: drc_pkg::MUX_ADDR_W];
		end else begin
			mux_q <= pin_q.addr[drc_pkg::ROW_ADDR_LSB +: drc_pkg::MUX_ADDR_W];
		end
	end

	assign row_strobe_lower_n = row_lower_q;
	assign row_strobe_upper_n = row_upper_q;
	assign col_strobe_n = state_bits_q.col_n;
	assign width_ack_hi_n = ack_hi_q;
	assign width_ack_lo_n = ack_lo_q;
	assign dram_mux_addr = mux_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_ack_pair;
		width_ack_hi_n == width_ack_lo_n && width_ack_hi_n == state_bits_q.ack_n;
	endproperty
	a_ack_pair: assert property (p_ack_pair) else $error("acks split");

	property p_begin;
		state_q == drc_pkg::ST_BEGIN |=> state_q == drc_pkg::ST_IDLE
			&& col_strobe_n == 4'hf && width_ack_hi_n && row_strobe_lower_n
			&& row_strobe_upper_n;
	endproperty
	a_begin: assert property (p_begin) else $error("power-up did not reach idle");

	property p_row_phase;
		state_q == drc_pkg::ST_IDLE && !refresh_request && !pin_q.strobe_n
			|=> state_q inside {drc_pkg::ST_ROW0, drc_pkg::ST_ROW1,
				drc_pkg::ST_ROW2, drc_pkg::ST_ROW3}
			&& col_strobe_n == 4'hf && width_ack_hi_n
			&& (row_strobe_lower_n != row_strobe_upper_n)
			##1 !is_column(state_q) == 1'b0;
	endproperty
	a_row_phase: assert property (p_row_phase) else $error("row phase wrong");

	property p_row_select;
		state_bits_q.refresh_n && !state_bits_q.row_n
			|-> row_strobe_upper_n == !$past(pin_q.addr[drc_pkg::ROW_SEL_BIT])
			&& row_strobe_lower_n == $past(pin_q.addr[drc_pkg::ROW_SEL_BIT]);
	endproperty
	a_row_select: assert property (p_row_select) else $error("wrong row strobe");

	property p_start_col;
		state_q == drc_pkg::ST_ROW1 |=> !col_strobe_n[1] && col_strobe_n[0];
	endproperty
	a_start_col: assert property (p_start_col) else $error("start column wrong");

	property p_col_ack;
		is_column(state_q) |-> !width_ack_hi_n && col_strobe_n != 4'hf
			&& dram_mux_addr == $past(pin_q.addr[11:2]);
	endproperty
	a_col_ack: assert property (p_col_ack) else $error("column ack or address wrong");

	property p_col_hold;
		is_column(state_q) && !pin_q.strobe_n |=> state_q == $past(state_q);
	endproperty
	a_col_hold: assert property (p_col_hold) else $error("access cut short");

	property p_col_end;
		is_column(state_q) && pin_q.strobe_n |=> state_q == drc_pkg::ST_IDLE
			&& width_ack_hi_n && col_strobe_n == 4'hf;
	endproperty
	a_col_end: assert property (p_col_end) else $error("access did not end");

	property p_ref_first;
		state_q == drc_pkg::ST_IDLE && refresh_request
			|=> state_q == drc_pkg::ST_REFRESH_FIRST;
	endproperty
	a_ref_first: assert property (p_ref_first) else $error("refresh lost priority");

	property p_ref_wait;
		is_column(state_q) && refresh_request |=> !is_refresh(state_q);
	endproperty
	a_ref_wait: assert property (p_ref_wait) else $error("refresh broke an access");

	property p_ref_seq;
		state_q == drc_pkg::ST_REFRESH_FIRST
			&& !row_strobe_lower_n && !row_strobe_upper_n
			|=> (state_q == drc_pkg::ST_REFRESH_SECOND && !row_strobe_lower_n
				&& !row_strobe_upper_n) [*2]
			##1 state_q == drc_pkg::ST_IDLE && row_strobe_upper_n;
	endproperty
	a_ref_seq: assert property (p_ref_seq) else $error("refresh sequence wrong");

	property p_ref_addr;
		is_refresh(state_q) |-> !dram_mux_addr[drc_pkg::MUX_ADDR_W-1]
			&& dram_mux_addr[ROW_W-1:0] == $past(refresh_row);
	endproperty
	a_ref_addr: assert property (p_ref_addr) else $error("refresh address wrong");

endmodule

// file: verilog/drc_pkg.sv
/*
 drc_pkg: constants, state names, state-bit layout and pin bundle of the
 dram refresh controller.
 assumes a single 25 MHz ref_clk and a processor bus on asynchronous pins.
*/
// Contract
// - both acks high insert waits; 10 is 8, 01 is 16, 00 is 32 bits.
// - both acknowledge outputs follow one common acknowledge, asserting and releasing together.
// - eighteen states in nine bits; strobes, ack, refresh taken straight from bits; code registers row strobes and acks in own flops.
// - power-up state is all low; first edge moves to idle, everything inactive.
// - request from idle picks column from address bits 1:0, one row-phase clock.
// - row bit with top address bit picks upper or lower row; refresh drives both.
// - after row phase, size picks column strobes from start column, never past four.
// - every column state asserts the acknowledge together with its column strobes.
// - column state holds until master strobe rises, then idle releases everything.
// - refresh request beats a memory request arriving in idle at once.
// - refresh arriving mid-access waits until the access returns to idle.
// - refresh runs two states, both rows low, for the minimum row period.
// - refresh timer counts 0 to 311, pulse at 311 sets request latch.
// - request latch clears when the machine shows its refresh-active state bit.
// - 9-bit row counter increments on each due pulse; refresh uses its value.
// - refresh puts the row count on the low nine address lines, all rows low.
// - mux gives address 21:12 in idle and row, 11:2 in columns, count in refresh.
// - two row-strobe outputs and four column-strobe outputs.
package drc_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int REF_RAS_MIN_NS = 90;
	// least time rounds up; refresh state one covers the first cycle
	localparam int REF_RAS_MIN_CYCLES = (REF_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_SECOND_CYCLES =
		(REF_RAS_MIN_CYCLES > 2) ? REF_RAS_MIN_CYCLES - 1 : 1;
	localparam int HOLD_W = 4;

	localparam int REFRESH_PERIOD = 312;
	localparam int ROW_CNT_W = 9;
	localparam int MUX_ADDR_W = 10;
	localparam int ADDR_W = 23;
	localparam int ROW_SEL_BIT = 22;
	localparam int ROW_ADDR_LSB = 12;
	localparam int COL_ADDR_LSB = 2;
	localparam int COLS = 4;

	localparam logic [1:0] SIZE_8 = 2'h1;
	localparam logic [1:0] SIZE_16 = 2'h2;
	localparam logic [1:0] SIZE_24 = 2'h3;
	localparam logic [1:0] SIZE_32 = 2'h0;

	typedef enum logic [4:0] {
		ST_BEGIN, ST_IDLE,
		ST_ROW0, ST_ROW1, ST_ROW2, ST_ROW3,
		ST_C0X1, ST_C0X2, ST_C0X3, ST_C0X4,
		ST_C1X1, ST_C1X2, ST_C1X3,
		ST_C2X1, ST_C2X2,
		ST_C3X1,
		ST_REFRESH_FIRST, ST_REFRESH_SECOND
	} drc_state_t;

	// col_n[i] drives column i; all fields active low except the two tags
	typedef struct packed {
		logic [3:0] col_n;
		logic row_n;
		logic ack_n;
		logic refresh_n;
		logic state_tag_hi;
		logic state_tag_lo;
	} drc_state_bits_t;

	typedef struct packed {
		logic strobe_n;
		logic [1:0] size;
		logic [ADDR_W-1:0] addr;
	} drc_pin_t;

	localparam drc_pin_t PIN_RESET = '{strobe_n: 1'b1, size: 2'h0, addr: '0};
	localparam drc_state_bits_t BITS_RESET = '0;

endpackage

// file: verilog/drc_refresh_timer.sv
/*
 drc_refresh_timer: free-running refresh timer, request latch and refresh
 row counter.
 assumes refresh_ack comes from a state bit on the same clock.
*/
`timescale 1ns/1ps
module drc_refresh_timer #(
	parameter int PERIOD = drc_pkg::REFRESH_PERIOD,
	parameter int ROW_W = drc_pkg::ROW_CNT_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic refresh_ack,
	output logic due_pulse,
	output logic refresh_request,
	output logic [ROW_W-1:0] refresh_row
);
	localparam int CNT_W = $clog2(PERIOD);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

	if (PERIOD < 2 || ROW_W < 1) begin : g_bad
		$error("drc_refresh_timer: period or row width out of range");
	end

	logic [CNT_W-1:0] cnt_q;
	logic req_q;
	logic [ROW_W-1:0] row_q;

	// unlatched, true for the whole cycle at the last count
	assign due_pulse = (cnt_q == LAST);
	assign refresh_request = req_q;
	assign refresh_row = row_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (due_pulse) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// a due pulse in the acknowledge cycle wins, so no refresh is lost
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			req_q <= 1'b0;
		end else begin
			req_q <= due_pulse | (req_q & ~refresh_ack);
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			row_q <= '0;
		end else if (due_pulse) begin
			row_q <= row_q + 1'b1;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_period;
		due_pulse |=> !due_pulse && cnt_q == '0 && refresh_request;
	endproperty
	a_period: assert property (p_period) else $error("timer wrap or latch wrong");

	property p_ack_clear;
		refresh_ack && !due_pulse |=> !refresh_request;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("request latch not cleared");

	property p_row_step;
		due_pulse |=> refresh_row == $past(refresh_row) + 1'b1;
	endproperty
	a_row_step: assert property (p_row_step) else $error("row counter did not step");

endmodule
